// ==== opsm_pkg.sv ====
package opsm_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_P1_DIR = 8'h00;
    localparam logic [7:0] IDX_P2_DIR = 8'h01;
    localparam logic [7:0] IDX_P1_DATA = 8'h02;
    localparam logic [7:0] IDX_P2_DATA = 8'h03;
    localparam logic [7:0] IDX_P3_DIR = 8'h04;
    localparam logic [7:0] IDX_P4_DIR = 8'h05;
    localparam logic [7:0] IDX_P3_DATA = 8'h06;
    localparam logic [7:0] IDX_P4_DATA = 8'h07;
    localparam logic [7:0] IDX_P3_CSR = 8'h0f;
    localparam logic [7:0] IDX_RAM_CTL = 8'h14;
    // field positions
    localparam int MODE_LSB = 5;
    localparam int RAM_STANDBY_REQUEST_N_BIT = 7;
    localparam int RAM_ENABLE_BIT = 6;
    localparam int CSR_IS3_BIT = 7;
    // mode codes
    localparam logic [2:0] MODE_SINGLE = 3'h7;
    localparam logic [2:0] MODE_MUX_PART = 3'h6;
    localparam logic [2:0] MODE_NMUX_PART = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h4;
    localparam logic [2:0] MODE_MUX_A = 3'h0;
    localparam logic [2:0] MODE_NMUX_FULL = 3'h1;
    localparam logic [2:0] MODE_MUX_B = 3'h2;
    localparam logic [2:0] MODE_RESET = 3'h7;
    // reset values; port data value is arbitrary, software must not rely on it
    localparam logic [7:0] RAM_CTL_RESET = 8'h40;
    localparam logic [7:0] PORT_DATA_RESET = 8'h00;
    // internal ram window
    localparam logic [15:0] RAM_BASE = 16'h0080;
    localparam logic [15:0] RAM_TOP = 16'h00ff;
    // timing: output strobe width, one bus cycle
    localparam int CLK_NS = 5;
    localparam int STROBE_NS = 20;
    localparam logic [2:0] STROBE_CYCLES = 3'((STROBE_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic {BUS_IDLE = 1'b0, BUS_RUN = 1'b1} opsm_bus_t;

    typedef struct packed {
        logic nmiN;
        logic stbyN;
        logic resN;
        logic sc1;
        logic [7:0] p1;
        logic [4:0] p2;
        logic [7:0] p3;
        logic [7:0] p4;
    } opsm_pins_t;

    typedef struct packed {
        logic eClk;
        logic sc1Out;
        logic sc1Oe;
        logic sc2Out;
        logic sc2Oe;
        logic [7:0] p1Out;
        logic [7:0] p1Oe;
        logic [4:0] p2Out;
        logic [4:0] p2Oe;
        logic [7:0] p3Out;
        logic [7:0] p3Oe;
        logic [7:0] p4Out;
        logic [7:0] p4Oe;
    } opsm_pad_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } opsm_req_t;

    typedef struct packed {
        logic ack;
        logic ramSelect;
        logic [7:0] rdata;
    } opsm_ans_t;

    typedef struct packed {
        logic cmpEn;
        logic cmpLvl;
        logic sclkEn;
        logic sclkLvl;
        logic txEn;
        logic txLvl;
    } opsm_perout_t;

    typedef struct packed {
        logic capture;
        logic sclk;
        logic rx;
    } opsm_perin_t;
endpackage : opsm_pkg

// ==== opsm_port_setup.sv ====
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - latch strap pins into mode at reset release
// - mode bits read-only at bits seven to five
// - codes 7, 6, 5 select modes; 4 unused
// - single chip, multiplexed, non-multiplexed bus styles
// - modes 0,2,6: address strobe, port three muxed
// - mode 5: io select strobe, port four address
// - mode 7: port three strobes, port four io
// - port two pins carry timer and serial
// - bus clock is clock divided by four
// - nmi recognised on falling edge only
// - port data undefined after reset
// - standby sampled at E rise, reset at fall
// - standby ignores instruction boundaries
// - ram disabled sends accesses to external bus in expanded modes
// - port data reads return pin states
module opsm_port_setup
    import opsm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire opsm_pins_t padIn,
    output opsm_pad_t padOut,
    input wire opsm_req_t coreReq,
    output opsm_ans_t coreAns,
    input wire opsm_perout_t perOut,
    output opsm_perin_t perIn,
    output logic nmiFall
);
    typedef struct packed {
        opsm_pins_t sync1;
        opsm_pins_t sync2;
        logic resPrev;
        logic nmiPrev;
        logic sc1Prev;
        logic [1:0] ePhase;
        logic [2:0] mode;
        logic stbyArm;
        logic standby;
        logic [7:0] p1Dir;
        logic [7:0] p1Data;
        logic [4:0] p2Dir;
        logic [4:0] p2Data;
        logic [7:0] p3Dir;
        logic [7:0] p3Data;
        logic [7:0] p4Dir;
        logic [7:0] p4Data;
        logic [7:0] ramCtl;
        logic is3Flag;
        logic [2:0] strobeCnt;
        opsm_bus_t bus;
        logic busWrite;
        logic [15:0] busAddr;
        logic [7:0] busData;
        logic ahbPend;
        logic ahbWrite;
        logic ahbOk;
        logic [7:0] ahbIdx;
        logic hreadyout;
        logic [31:0] hrdata;
        opsm_ans_t ans;
        opsm_pad_t pad;
        opsm_perin_t perIn;
        logic nmiFall;
    } opsm_state_t;

    opsm_state_t s;
    opsm_state_t next_s;

    // register index decode, used by both the read and the write path
    function automatic logic regKnown(input logic [7:0] idx);
        regKnown = (idx <= IDX_P4_DATA) || (idx == IDX_P3_CSR) || (idx == IDX_RAM_CTL);
    endfunction : regKnown

    // modes that run the multiplexed address/data bus
    function automatic logic isMux(input logic [2:0] m);
        isMux = (m == MODE_MUX_A) || (m == MODE_MUX_B) || (m == MODE_MUX_PART);
    endfunction : isMux

    // modes that run the non-multiplexed bus
    function automatic logic isNmux(input logic [2:0] m);
        isNmux = (m == MODE_NMUX_PART) || (m == MODE_NMUX_FULL);
    endfunction : isNmux

    // next-state logic
    always_comb begin
        logic ramHit;
        logic expanded;
        logic run;
        logic [7:0] rd;
        logic [1:0] ph;
        logic strobeIn;
        ramHit = 1'b0;
        expanded = 1'b0;
        run = 1'b0;
        rd = 8'h00;
        ph = 2'h0;
        strobeIn = s.mode == MODE_SINGLE && s.sc1Prev && ~s.sync2.sc1;
        next_s = s;

        // two-stage synchronisers; only stage two is looked at
        next_s.sync1 = padIn;
        next_s.sync2 = s.sync1;
        next_s.resPrev = s.sync2.resN;
        next_s.nmiPrev = s.sync2.nmiN;
        next_s.sc1Prev = s.sync2.sc1;
        next_s.nmiFall = s.nmiPrev & ~s.sync2.nmiN;
        next_s.perIn.capture = s.sync2.p2[0];
        next_s.perIn.sclk = s.sync2.p2[2];
        next_s.perIn.rx = s.sync2.p2[3];

        // bus cycle clock: four clk periods per cycle
        next_s.ePhase = s.ePhase + 2'h1;

        // strap capture on release of the reset pin; software has no path here
        if (~s.resPrev & s.sync2.resN) begin
            next_s.mode = s.sync2.p2[2:0];
        end

        // standby: sampled at E rise, takes effect at the next E fall
        if (s.ePhase == 2'h1) begin
            next_s.stbyArm = ~s.sync2.stbyN;
        end

        // input strobe in single chip; set wins over the clearing read
        if (strobeIn) begin
            next_s.is3Flag = 1'b1;
        end
        if (s.strobeCnt != 3'h0) begin
            next_s.strobeCnt = s.strobeCnt - 3'h1;
        end

        // register bus, address phase
        next_s.hreadyout = 1'b1;
        next_s.ahbPend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_s.ahbPend = 1'b1;
            next_s.ahbWrite = hwrite;
            next_s.ahbIdx = haddr[9:2];
            next_s.ahbOk = (haddr[31:10] == 22'h000000) && regKnown(haddr[9:2]);
            next_s.hreadyout = 1'b0;
        end

        // register bus, data phase: reads show pins, not latches
        if (s.ahbPend) begin
            unique case (s.ahbIdx)
                IDX_P1_DATA: rd = s.sync2.p1;
                IDX_P2_DATA: rd = {s.mode, s.sync2.p2};
                IDX_P3_DATA: rd = s.sync2.p3;
                IDX_P4_DATA: rd = s.sync2.p4;
                IDX_P3_CSR: rd = {s.is3Flag, 7'h00};
                IDX_RAM_CTL: rd = {s.ramCtl[7:6], 6'h00};
                default: rd = 8'h00; // direction registers are write-only
            endcase
            if (~s.ahbOk) begin
                rd = 8'h00;
            end
            next_s.hrdata = {24'h000000, rd};
            if (~s.ahbWrite && s.ahbOk && s.ahbIdx == IDX_P3_DATA) begin
                next_s.is3Flag = strobeIn; // a strobe in the same cycle keeps the flag set
            end
            if (s.ahbWrite && s.ahbOk) begin
                unique case (s.ahbIdx)
                    IDX_P1_DIR: next_s.p1Dir = hwdata[7:0];
                    IDX_P2_DIR: next_s.p2Dir = hwdata[4:0];
                    IDX_P1_DATA: next_s.p1Data = hwdata[7:0];
                    IDX_P2_DATA: next_s.p2Data = hwdata[4:0];
                    IDX_P3_DIR: next_s.p3Dir = hwdata[7:0];
                    IDX_P4_DIR: next_s.p4Dir = hwdata[7:0];
                    IDX_P3_DATA: begin
                        next_s.p3Data = hwdata[7:0];
                        if (s.mode == MODE_SINGLE) begin
                            next_s.strobeCnt = STROBE_CYCLES;
                        end
                    end
                    IDX_P4_DATA: next_s.p4Data = hwdata[7:0];
                    IDX_RAM_CTL: next_s.ramCtl = {hwdata[7:6], 6'h00};
                    default: next_s.ramCtl = s.ramCtl;
                endcase
            end
        end

        // core access steering; disabled ram goes out on the bus in expanded modes, single chip answers at once with zero
        ramHit = s.ramCtl[RAM_ENABLE_BIT] && coreReq.addr >= RAM_BASE
            && coreReq.addr <= RAM_TOP;
        expanded = isMux(s.mode) || isNmux(s.mode);
        next_s.ans.ack = 1'b0;
        next_s.ans.ramSelect = 1'b0;
        if (coreReq.req && ~s.ans.ack && s.bus == BUS_IDLE && ~s.standby) begin
            if (ramHit) begin
                next_s.ans.ack = 1'b1;
                next_s.ans.ramSelect = 1'b1;
                next_s.ans.rdata = 8'h00;
            end else if (~expanded) begin
                // no bus in this mode: answer at once with zero
                next_s.ans.ack = 1'b1;
                next_s.ans.rdata = 8'h00;
            end else if (s.ePhase == 2'h3) begin
                next_s.bus = BUS_RUN;
                next_s.busWrite = coreReq.write;
                next_s.busAddr = coreReq.addr;
                next_s.busData = coreReq.wdata;
            end
        end

        // external cycle ends with E; read data from synchronised port three
        unique case (s.bus)
            BUS_RUN: begin
                if (s.ePhase == 2'h3) begin
                    next_s.bus = BUS_IDLE;
                    next_s.ans.ack = 1'b1;
                    next_s.ans.rdata = s.busWrite ? 8'h00 : s.sync2.p3;
                end
            end
            BUS_IDLE: begin
                next_s.bus = next_s.bus;
            end
        endcase

        // internal reset from pin low or standby entry; standby leaves only by reset
        if (~s.sync2.resN) begin
            next_s.standby = 1'b0;
            next_s.ramCtl = RAM_CTL_RESET;
        end
        if (~s.sync2.resN || (s.ePhase == 2'h3 && s.stbyArm)) begin
            if (s.sync2.resN) begin
                next_s.standby = 1'b1;
            end
            next_s.stbyArm = 1'b0;
            next_s.p1Dir = 8'h00;
            next_s.p2Dir = 5'h00;
            next_s.p3Dir = 8'h00;
            next_s.p4Dir = 8'h00;
            // data latches keep no defined value; dir cleared in the same cycle so nothing drives
            next_s.p1Data = PORT_DATA_RESET;
            next_s.p2Data = PORT_DATA_RESET[4:0];
            next_s.p3Data = PORT_DATA_RESET;
            next_s.p4Data = PORT_DATA_RESET;
            next_s.is3Flag = 1'b0;
            next_s.strobeCnt = 3'h0;
            next_s.bus = BUS_IDLE;
        end

        // pad drive, from the values that the registers are about to take
        ph = next_s.ePhase;
        run = next_s.bus == BUS_RUN;
        next_s.pad.eClk = ph[1] & ~next_s.standby;
        next_s.pad.p1Out = next_s.p1Data;
        next_s.pad.p1Oe = next_s.p1Dir;
        // port two: peripheral functions override the latch where enabled
        next_s.pad.p2Out = next_s.p2Data;
        next_s.pad.p2Oe = next_s.p2Dir;
        if (perOut.cmpEn) begin
            next_s.pad.p2Out[1] = perOut.cmpLvl;
            next_s.pad.p2Oe[1] = 1'b1;
        end
        if (perOut.sclkEn) begin
            next_s.pad.p2Out[2] = perOut.sclkLvl;
            next_s.pad.p2Oe[2] = 1'b1;
        end
        if (perOut.txEn) begin
            next_s.pad.p2Out[4] = perOut.txLvl;
            next_s.pad.p2Oe[4] = 1'b1;
        end
        next_s.pad.p3Out = next_s.p3Data;
        next_s.pad.p3Oe = 8'h00;
        next_s.pad.p4Out = next_s.p4Data;
        next_s.pad.p4Oe = 8'h00;
        next_s.pad.sc1Out = 1'b0;
        next_s.pad.sc1Oe = 1'b0;
        next_s.pad.sc2Out = 1'b1;
        next_s.pad.sc2Oe = 1'b0;
        if (next_s.mode == MODE_SINGLE) begin
            // single chip: sc1 is the input strobe, sc2 the output strobe
            next_s.pad.p3Oe = next_s.p3Dir;
            next_s.pad.p4Oe = next_s.p4Dir;
            next_s.pad.sc2Out = next_s.strobeCnt == 3'h0;
            next_s.pad.sc2Oe = 1'b1;
        end else if (isMux(next_s.mode)) begin
            // low address only while the strobe is up on reads, through phase one on writes; released early so the
            // two-stage pin sync holds peripheral data, not our address, at the end
            next_s.pad.sc1Out = run && ph == 2'h0;
            next_s.pad.sc1Oe = 1'b1;
            next_s.pad.p3Out = ph[1] ? next_s.busData : next_s.busAddr[7:0];
            next_s.pad.p3Oe = {8{run && (ph == 2'h0 || next_s.busWrite)}};
            next_s.pad.p4Out = next_s.busAddr[15:8];
            next_s.pad.p4Oe = next_s.p4Dir;
        end else if (isNmux(next_s.mode)) begin
            // io select is active low for the whole external cycle
            next_s.pad.sc1Out = ~run;
            next_s.pad.sc1Oe = 1'b1;
            next_s.pad.p3Out = next_s.busData;
            next_s.pad.p3Oe = {8{run && next_s.busWrite}};
            next_s.pad.p4Out = next_s.busAddr[7:0];
            next_s.pad.p4Oe = next_s.p4Dir;
        end else begin
            next_s.pad.p1Oe = 8'h00;
            next_s.pad.p2Oe = 5'h00;
        end
        if (isMux(next_s.mode) || isNmux(next_s.mode)) begin
            next_s.pad.sc2Out = ~(run && next_s.busWrite);
            next_s.pad.sc2Oe = 1'b1;
        end
        // during standby every pin except eClk floats; eClk is held low
        if (next_s.standby) begin
            next_s.pad.p1Oe = 8'h00;
            next_s.pad.p2Oe = 5'h00;
            next_s.pad.p3Oe = 8'h00;
            next_s.pad.p4Oe = 8'h00;
            next_s.pad.sc1Oe = 1'b0;
            next_s.pad.sc2Oe = 1'b0;
        end
    end

    // state register; async reset loads constants only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.sync1 <= '1;
            s.sync2 <= '1;
            s.resPrev <= 1'b1;
            s.nmiPrev <= 1'b1;
            s.sc1Prev <= 1'b1;
            s.mode <= MODE_RESET;
            s.ramCtl <= RAM_CTL_RESET;
            s.p1Data <= PORT_DATA_RESET;
            s.p2Data <= PORT_DATA_RESET[4:0];
            s.p3Data <= PORT_DATA_RESET;
            s.p4Data <= PORT_DATA_RESET;
            s.bus <= BUS_IDLE;
            s.hreadyout <= 1'b1;
            s.pad.sc2Out <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register, all but hresp, which is tied low
    assign hreadyout = s.hreadyout;
    assign hrdata = s.hrdata;
    assign hresp = 1'b0;
    assign padOut = s.pad;
    assign coreAns = s.ans;
    assign perIn = s.perIn;
    assign nmiFall = s.nmiFall;
endmodule : opsm_port_setup
`default_nettype wire

// ==== opsm_port_setup_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module opsm_port_setup_checker
    import opsm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire opsm_pins_t padIn,
    input wire opsm_pad_t padOut,
    input wire opsm_req_t coreReq,
    input wire opsm_ans_t coreAns,
    input wire opsm_perout_t perOut,
    input wire logic nmiFall
);
    logic [3:0] resHist;
    logic resQuiet;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // an internal reset may cut an e cycle short, so shape checks wait for a quiet reset pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) resHist <= 4'h0;
        else resHist <= {resHist[2:0], padIn.resN};
    end
    assign resQuiet = (&resHist) & padIn.resN;
    sequence s_take; hsel && htrans[1] && hready; endsequence
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    bus_wait_state_a: assert property (s_take |=> s_wait)
        else $error("bus transfer without one wait state");
    bus_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    eclk_quarter_a: assert property (disable iff (rst || !resQuiet)
        ($rose(padOut.eClk) |=> padOut.eClk ##1 !padOut.eClk)
        and ($fell(padOut.eClk) |=> !padOut.eClk)) else $error("bus clock shape wrong");
    strobe_dir_a: assert property (padOut.sc1Oe |-> padOut.sc2Oe)
        else $error("strobe one driven without read write line");
    nmi_edge_a: assert property ($fell(padIn.nmiN) |-> ##[2:5] nmiFall)
        else $error("nmi falling edge missed");
    nmi_once_a: assert property (nmiFall |=> !nmiFall [*6])
        else $error("nmi recognised on level");
    standby_stop_a: assert property ($fell(padIn.stbyN) |-> ##[3:12]
        (padOut.p1Oe == 8'h00 && !padOut.sc2Oe)) else $error("standby did not release pins");
    ack_pulse_a: assert property (coreAns.ack |=> !coreAns.ack)
        else $error("core ack longer than one cycle");
    ram_hit_a: assert property (coreAns.ramSelect |-> coreAns.ack &&
        coreReq.addr >= RAM_BASE && coreReq.addr <= RAM_TOP) else $error("ram select wrong");
    cmp_pin_a: assert property (perOut.cmpEn |=> padOut.p2Oe[1] &&
        padOut.p2Out[1] == $past(perOut.cmpLvl)) else $error("compare pin not driven");
    tx_pin_a: assert property (perOut.txEn |=> padOut.p2Oe[4] &&
        padOut.p2Out[4] == $past(perOut.txLvl)) else $error("transmit pin not driven");
endmodule : opsm_port_setup_checker
bind opsm_port_setup opsm_port_setup_checker chk (.clk(clk), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .padIn(padIn),
    .padOut(padOut), .coreReq(coreReq), .coreAns(coreAns), .perOut(perOut), .nmiFall(nmiFall));
`default_nettype wire

// ==== opsm_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module opsm_far_model
    import opsm_pkg::*;
(
    input wire logic clk,
    input wire logic resN,
    input wire logic [2:0] strapCode,
    input wire logic [7:0] busData,
    input wire opsm_pad_t padOut,
    output logic strapEn,
    output logic [2:0] strapLvl,
    output logic [7:0] p3Lvl
);
    logic [3:0] holdCnt;
    // straps stay put through reset and eight clocks beyond, then peripherals take over
    always_ff @(posedge clk) begin
        if (!resN) holdCnt <= 4'h0;
        else if (holdCnt != 4'hf) holdCnt <= holdCnt + 4'h1;
    end
    assign strapEn = !resN || (holdCnt < 4'h8);
    assign strapLvl = strapCode;
    // peripheral answers on the data bus wherever the device does not drive it
    assign p3Lvl = (padOut.p3Oe & padOut.p3Out) | (~padOut.p3Oe & busData);
endmodule : opsm_far_model
`default_nettype wire

// ==== opsm_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
    import opsm_pkg::*;
;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, nmiFall;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic nmiN = 1, stbyN = 1, resN = 0, sc1x = 1, strapEn;
    logic [7:0] p1x = 8'h00, p3x = 8'h00, p4x = 8'h00, p3w;
    logic [4:0] p2x = 5'h00, p2w;
    logic [2:0] strap = 3'h7, strapLvl;
    opsm_pins_t padIn;
    opsm_pad_t padOut;
    opsm_req_t coreReq = '0;
    opsm_ans_t coreAns;
    opsm_perout_t perOut = '0;
    opsm_perin_t perIn;
    int fails = 0, cmpCount = 0, seed = 79;
    // wire levels from every driver's enable
    assign p2w[2:0] = (padOut.p2Oe[2:0] & padOut.p2Out[2:0])
        | (~padOut.p2Oe[2:0] & (strapEn ? strapLvl : p2x[2:0]));
    assign p2w[4:3] = (padOut.p2Oe[4:3] & padOut.p2Out[4:3]) | (~padOut.p2Oe[4:3] & p2x[4:3]);
    assign padIn = {nmiN, stbyN, resN, padOut.sc1Oe ? padOut.sc1Out : sc1x,
        (padOut.p1Oe & padOut.p1Out) | (~padOut.p1Oe & p1x), p2w, p3w,
        (padOut.p4Oe & padOut.p4Out) | (~padOut.p4Oe & p4x)};
    opsm_port_setup uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .padIn(padIn), .padOut(padOut), .coreReq(coreReq),
        .coreAns(coreAns), .perOut(perOut), .perIn(perIn), .nmiFall(nmiFall));
    opsm_far_model far (.clk(clk), .resN(resN), .strapCode(strap), .busData(p3x),
        .padOut(padOut), .strapEn(strapEn), .strapLvl(strapLvl), .p3Lvl(p3w));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk_bus(input string what, input logic [7:0] e, input logic [7:0] g);
        cmpCount++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_bus
    task automatic chk_pin(input string what, input logic [7:0] e, input logic [7:0] g);
        cmpCount++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_pin
    // one single transfer; entered just after a rising edge, left just after one
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
        output logic [7:0] v);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do @(negedge clk); while (hreadyout !== 1'b1);
        @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(negedge clk); while (hreadyout !== 1'b1);
        v = hrdata[7:0];
        @(posedge clk);
    endtask : ahb
    // core byte read; port four pins are captured at the first sample and while the bus clock is high
    task automatic core(input logic [15:0] a, output logic sel, output logic [7:0] d,
        output logic [7:0] p4o, output logic [7:0] p4e);
        int n;
        n = 0;
        coreReq <= {1'b1, 1'b0, a, 8'h00};
        do begin
            @(negedge clk);
            n++;
            if (padOut.eClk === 1'b1 || n == 1) {p4o, p4e} = {padOut.p4Out, padOut.p4Oe};
        end while (coreAns.ack !== 1'b1 && n < 40);
        sel = coreAns.ramSelect;
        d = coreAns.rdata;
        chk_pin("core ack", 8'h01, {7'h0, coreAns.ack});
        @(posedge clk);
        coreReq.req <= 1'b0;
        @(posedge clk); // a following request starts on a fresh edge
    endtask : core
    task automatic count_hi(input int which, input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk);
            n += (which == 0) ? padOut.eClk : (which == 1) ? nmiFall : !padOut.sc2Out;
        end
        @(posedge clk);
    endtask : count_hi
    task automatic pulse_res(input logic [2:0] c);
        strap <= c;
        resN <= 1'b0;
        repeat (6) @(posedge clk);
        resN <= 1'b1;
        repeat (20) @(posedge clk);
    endtask : pulse_res
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial begin
        #200000;
        fails++;
        $display("Error watchdog expected finish seen timeout");
        close_out();
    end
    initial begin
        logic [7:0] v, d, p4o, p4e, ea;
        logic sel;
        logic [2:0] c;
        int n;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pulse_res(3'h7);
        ahb(0, IDX_RAM_CTL, 8'h00, v); chk_bus("ram ctl reset", RAM_CTL_RESET, v);
        ahb(0, 8'hfc, 8'h00, v); chk_bus("unmapped read", 8'h00, v);
        $display("test reset values done");
        // strap codes 4 to 7, each then its pin assignment and a core access
        for (int i = 4; i < 8; i++) begin
            c = 3'(i);
            p3x <= 8'($random(seed));
            pulse_res(c);
            ahb(0, IDX_P2_DATA, 8'h00, v); chk_bus("mode bits", {c, p2x}, v);
            ahb(1, IDX_P2_DATA, 8'h00, v);
            ahb(0, IDX_P2_DATA, 8'h00, v); chk_bus("mode read only", {c, p2x}, v);
            chk_pin("sc1 dir", {7'h0, c == 5 || c == 6}, {7'h0, padOut.sc1Oe});
            chk_pin("sc2 dir", {7'h0, c != 4}, {7'h0, padOut.sc2Oe});
            ahb(1, IDX_P4_DIR, 8'h0f, v);
            core(16'h1234, sel, d, p4o, p4e);
            chk_pin("p4 dir", (c == 4) ? 8'h00 : 8'h0f, p4e);
            ea = (c == 6) ? 8'h02 : 8'h04;
            if (c == 5 || c == 6) begin
                chk_pin("p4 address", ea, p4o & 8'h0f);
                chk_bus("ext data", p3x, d);
            end
            if (c == 6) begin
                core(16'h0090, sel, d, p4o, p4e); chk_pin("ram hit", 8'h01, {7'h0, sel});
                ahb(1, IDX_RAM_CTL, 8'h00, v);
                core(16'h0090, sel, d, p4o, p4e); chk_pin("ram off", 8'h00, {7'h0, sel});
                chk_bus("ram off data", p3x, d);
            end
            $display("test mode %0d done", c);
        end
        // port data before direction, then pin readback
        d = 8'($random(seed));
        p1x <= 8'($random(seed));
        ahb(1, IDX_P1_DATA, d, v);
        ahb(1, IDX_P1_DIR, 8'hf0, v);
        repeat (4) @(posedge clk);
        chk_pin("p1 drive", {d[7:4], 4'hf}, {padOut.p1Out[7:4], padOut.p1Oe[7:4]});
        ahb(0, IDX_P1_DATA, 8'h00, v); chk_bus("p1 pins", {d[7:4], p1x[3:0]}, v);
        ahb(1, IDX_P3_DATA, 8'h5a, v);
        // the write lands one edge before the task returns, so one low cycle is already gone
        count_hi(2, 10, n); chk_pin("out strobe", 8'(STROBE_CYCLES - 1), 8'(n));
        sc1x <= 1'b0;
        repeat (3) @(posedge clk);
        sc1x <= 1'b1;
        repeat (4) @(posedge clk);
        ahb(0, IDX_P3_CSR, 8'h00, v); chk_bus("in strobe flag", 8'h80, v & 8'h80);
        ahb(0, IDX_P3_DATA, 8'h00, v);
        ahb(0, IDX_P3_CSR, 8'h00, v); chk_bus("in strobe clear", 8'h00, v & 8'h80);
        $display("test ports done");
        repeat (8) begin
            p2x <= 5'($random(seed));
            perOut <= {1'b1, 1'($random(seed)), 2'b00, 1'b1, 1'($random(seed))};
            @(posedge clk);
        end
        perOut <= '0;
        repeat (6) @(posedge clk);
        chk_pin("p2 inputs", {5'h0, p2x[0], p2x[2], p2x[3]}, {5'h0, perIn});
        nmiN <= 1'b0;
        count_hi(1, 20, n); chk_pin("nmi pulses", 8'h01, 8'(n));
        nmiN <= 1'b1;
        count_hi(1, 10, n); chk_pin("nmi rise", 8'h00, 8'(n));
        $display("test timer serial nmi done");
        stbyN <= 1'b0;
        repeat (12) @(posedge clk);
        count_hi(0, 8, n); chk_pin("standby clock", 8'h00, 8'(n));
        chk_pin("standby pins", 8'h00, padOut.p1Oe);
        stbyN <= 1'b1;
        pulse_res(3'h7);
        count_hi(0, 8, n); chk_pin("clock quarter", 8'h04, 8'(n));
        ahb(0, IDX_RAM_CTL, 8'h00, v); chk_bus("ram ctl after", RAM_CTL_RESET, v);
        $display("test standby done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
